// ### flash_lock_pkg.sv
// package: command codes, field positions, reset values and timing for the register-access command block
package flash_lock_pkg;
  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] cmd_write_enable       = 8'h06;
  localparam logic [7:0] cmd_read_sector_lock   = 8'hE8;
  localparam logic [7:0] cmd_write_sector_lock  = 8'hE5;
  localparam logic [7:0] cmd_read_flag_register = 8'h70;
  localparam logic [7:0] cmd_clear_error_flags  = 8'h50;
  localparam logic [7:0] cmd_read_nv_config     = 8'hB5;
  localparam logic [7:0] cmd_write_nv_config    = 8'hB1;
  localparam logic [7:0] cmd_read_vol_config    = 8'h85;
  localparam logic [7:0] cmd_write_vol_config   = 8'h81;
  localparam logic [7:0] cmd_read_status        = 8'h05;
  // ****************************************
  // field positions
  // ****************************************
  localparam int lock_write_bit   = 0;
  localparam int lock_down_bit    = 1;
  localparam int flag_ctrl_bit    = 7;
  localparam int flag_erase_bit   = 5;
  localparam int flag_prog_bit    = 4;
  localparam int flag_vpp_bit     = 3;
  localparam int flag_prot_bit    = 1;
  localparam int flag_addr4_bit   = 0;
  localparam int status_busy_bit  = 0;
  localparam int status_latch_bit = 1;
  localparam logic [7:0] flag_error_mask = 8'h3A;
  localparam logic [7:0] lock_keep_mask  = 8'h03;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0]  lock_reset_val  = 8'h00;
  localparam logic [7:0]  vcfg_reset_val  = 8'hFB;
  localparam logic [15:0] nvcfg_reset_val = 16'hFFFF;
  // ****************************************
  // timing and sizes
  // ****************************************
  localparam int clk_hz            = 20_000_000;
  localparam int nvcfg_time_us     = 200;
  localparam int nvcfg_cycles      = nvcfg_time_us * (clk_hz / 1_000_000);
  localparam int sector_bits       = 9;
  localparam int sector_lsb        = 16;
endpackage

// ### spi_pin_sync.sv
// two-flop synchronisers for the serial pins and edge detection on the serial clock
`timescale 1ns/100ps
module spi_pin_sync (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic sclk_pin,
  input  wire logic cs_n_pin,
  input  wire logic din_pin,
  output logic      rise,
  output logic      fall,
  output logic      cs_n,
  output logic      din
);
  logic [2:0] sclk_ff;
  logic [1:0] cs_ff;
  logic [1:0] din_ff;
  // ****************************************
  // synchronisers
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_ff <= 3'h0;
      cs_ff   <= 2'h3;
      din_ff  <= 2'h0;
    end else begin
      sclk_ff <= {sclk_ff[1:0], sclk_pin};
      cs_ff   <= {cs_ff[0], cs_n_pin};
      din_ff  <= {din_ff[0], din_pin};
    end
  end
  // edges are taken between second and third stage only
  assign rise = sclk_ff[1] & ~sclk_ff[2];
  assign fall = ~sclk_ff[1] & sclk_ff[2];
  assign cs_n = cs_ff[1];
  assign din  = din_ff[1];
endmodule

// ### nv_cycle_timer.sv
// self-timed programming cycle counter for the non-volatile configuration
`timescale 1ns/100ps
module nv_cycle_timer #(
  parameter int cycles = 4000
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  logic [31:0] cnt_ff;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 32'h0000_0000;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && cnt_ff == 32'h0000_0000) begin
        cnt_ff <= 32'(cycles);
      end else if (cnt_ff == 32'h0000_0001) begin
        cnt_ff <= 32'h0000_0000;
        done   <= 1'b1;
      end else if (cnt_ff != 32'h0000_0000) begin
        cnt_ff <= cnt_ff - 32'h0000_0001;
      end
    end
  end
  assign busy = (cnt_ff != 32'h0000_0000);
endmodule

// ### flash_lock_config_register_ops.sv
// command interpreter for lock, flag and configuration register instructions of a serial flash
//
// Summary of operation
// [R1] lock read takes three-byte sector address
// [R2] address bits captured on rising clock
// [R3] lock byte shifted out on falling edges
// [R4] chip select high ends read, output released
// [R5] lock read rejected while cycle running
// [R6] four-byte mode uses 32-bit lock address
// [R7] lock-down freezes both bits until power-up
// [R8] write-lock blocks modify ops on sector
// [R9] host frames lock write: cmd, addr, byte
// [R10] lock write runs only on byte-eight boundary
// [R11] lock bits instant, latch cleared quickly after
// [R12] lock write rejected while cycle running
// [R13] register writes need write-enable latch set
// [R14] flag read anytime, repeats while selected
// [R15] clear-flags resets four error bits
// [R16] clear-flags ignores and keeps write-enable latch
// [R17] nv config write needs exactly sixteen bits
// [R18] nv write starts timed programming cycle
// [R19] busy bit during nv cycle, latch cleared after
// [R20] nv values take effect only after power-on; the active copy here only ever takes the fixed reset value
// [R21] volatile config write needs eight bits
// [R22] volatile write applies at once, clears latch
// [R23] reserved lock bits ignored, read as zero
`timescale 1ns/100ps
module flash_lock_config_register_ops #(
  parameter int nv_cycles  = flash_lock_pkg::nvcfg_cycles,
  parameter int sec_bits   = flash_lock_pkg::sector_bits
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                sclk_pin,
  input  wire logic                cs_n_pin,
  input  wire logic                serial_in_line,
  output logic                     serial_out_line,
  output logic                     serial_out_oe,
  input  wire logic                ext_busy,
  input  wire logic                four_byte_mode,
  input  wire logic                write_enable_cmd_ext,
  input  wire logic                err_erase_set,
  input  wire logic                err_prog_set,
  input  wire logic                err_vpp_set,
  input  wire logic                err_prot_set,
  input  wire logic [31:0]         modify_addr,
  output logic                     modify_blocked_ff,
  output logic                     write_enable_latch_ff,
  output logic                     write_in_progress_ff,
  output logic [7:0]               vol_config_ff,
  output logic [15:0]              nv_active_ff
);
  typedef enum logic [4:0] {
    st_cmd  = 5'b00001,
    st_addr = 5'b00010,
    st_din  = 5'b00100,
    st_dout = 5'b01000,
    st_skip = 5'b10000
  } phase_t;

  logic        rise, fall, cs_n, din;
  logic        nv_busy, nv_done;
  logic        busy;
  phase_t      phase_ff;
  logic [7:0]  cmd_ff;
  logic [31:0] addr_ff;
  logic [15:0] data_ff;
  logic [5:0]  cnt_ff;
  logic [7:0]  obyte_ff;
  logic [2:0]  obit_ff;
  logic        cs_d_ff;
  logic        nv_start_ff;
  logic [15:0] nv_store_ff;
  logic [7:0]  flags_ff;
  logic [1:0]  lock_mem [0:(1<<sec_bits)-1];
  logic [1:0]  lock_sel;
  logic [1:0]  mod_sel;
  logic        end_sel;
  logic        exec_lock_w, exec_vol_w, exec_nv_w, exec_clr, exec_wen;
  logic [5:0]  addr_len;
  logic [7:0]  out_byte;

  spi_pin_sync u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .sclk_pin (sclk_pin),
    .cs_n_pin (cs_n_pin),
    .din_pin  (serial_in_line),
    .rise     (rise),
    .fall     (fall),
    .cs_n     (cs_n),
    .din      (din)
  );

  nv_cycle_timer #(.cycles(nv_cycles)) u_nv (
    .mclk  (mclk),
    .rst   (rst),
    .start (nv_start_ff),
    .busy  (nv_busy),
    .done  (nv_done)
  );

  function automatic logic [sec_bits-1:0] sector_of(input logic [31:0] a);
    sector_of = a[flash_lock_pkg::sector_lsb +: sec_bits];
  endfunction

  assign busy     = ext_busy | nv_busy | nv_start_ff;
  assign addr_len = four_byte_mode ? 6'd32 : 6'd24; // [R6]
  assign end_sel  = cs_n & ~cs_d_ff;
  assign lock_sel = lock_mem[sector_of(addr_ff)];
  assign mod_sel  = lock_mem[sector_of(modify_addr)];

  // ****************************************
  // write-back decisions at deselect
  // ****************************************
  // byte-boundary checks: exact bit count or the instruction is dropped
  assign exec_wen    = end_sel && phase_ff == st_cmd && cnt_ff == 6'd8 && cmd_ff == flash_lock_pkg::cmd_write_enable;
  assign exec_clr    = end_sel && phase_ff == st_cmd && cnt_ff == 6'd8
                       && cmd_ff == flash_lock_pkg::cmd_clear_error_flags; // [R16]
  assign exec_lock_w = end_sel && phase_ff == st_din && cnt_ff == 6'd8 && write_enable_latch_ff
                       && !busy && cmd_ff == flash_lock_pkg::cmd_write_sector_lock; // [R10] [R12] [R13]
  assign exec_vol_w  = end_sel && phase_ff == st_din && cnt_ff == 6'd8 && write_enable_latch_ff
                       && !busy && cmd_ff == flash_lock_pkg::cmd_write_vol_config; // [R21] [R13]
  assign exec_nv_w   = end_sel && phase_ff == st_din && cnt_ff == 6'd16 && write_enable_latch_ff
                       && !busy && cmd_ff == flash_lock_pkg::cmd_write_nv_config; // [R17] [R13]

  // ****************************************
  // serial input sequencing
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_ff <= st_cmd;
      cmd_ff   <= 8'h00;
      addr_ff  <= 32'h0000_0000;
      data_ff  <= 16'h0000;
      cnt_ff   <= 6'h00;
      cs_d_ff  <= 1'b1;
    end else begin
      cs_d_ff <= cs_n;
      if (cs_n) begin
        phase_ff <= st_cmd;
        // upper address bits must not carry over into a three-byte frame
        addr_ff  <= 32'h0000_0000;
        if (!cs_d_ff) begin
          cnt_ff <= 6'h00;
        end
      end else if (rise) begin
        case (phase_ff)
          st_cmd: begin
            cmd_ff <= {cmd_ff[6:0], din};
            cnt_ff <= cnt_ff + 6'h01;
            if (cnt_ff == 6'd7) begin
              cnt_ff <= 6'h00;
              case ({cmd_ff[6:0], din})
                flash_lock_pkg::cmd_read_sector_lock,
                flash_lock_pkg::cmd_write_sector_lock: phase_ff <= st_addr; // [R1] [R9]
                flash_lock_pkg::cmd_write_nv_config,
                flash_lock_pkg::cmd_write_vol_config: phase_ff <= st_din;
                flash_lock_pkg::cmd_read_flag_register,
                flash_lock_pkg::cmd_read_nv_config,
                flash_lock_pkg::cmd_read_vol_config,
                flash_lock_pkg::cmd_read_status: phase_ff <= st_dout;
                default: cnt_ff <= 6'd8;
              endcase
            end else if (cnt_ff == 6'd8) begin
              phase_ff <= st_skip;
            end
          end
          st_addr: begin
            addr_ff <= {addr_ff[30:0], din}; // [R2]
            cnt_ff  <= cnt_ff + 6'h01;
            if (cnt_ff == addr_len - 6'd1) begin
              cnt_ff <= 6'h00;
              if (cmd_ff == flash_lock_pkg::cmd_write_sector_lock) begin
                phase_ff <= st_din;
              end else if (busy) begin
                phase_ff <= st_skip; // [R5]
              end else begin
                phase_ff <= st_dout;
              end
            end
          end
          st_din: begin
            data_ff <= {data_ff[14:0], din};
            if (cnt_ff != 6'd63) begin
              cnt_ff <= cnt_ff + 6'h01;
            end
          end
          st_dout: phase_ff <= st_dout;
          st_skip: phase_ff <= st_skip;
          default: phase_ff <= st_skip;
        endcase
      end
    end
  end

  // ****************************************
  // serial output
  // ****************************************
  function automatic logic [7:0] read_byte(input logic [7:0] c, input logic [1:0] lk, input logic [7:0] fl,
                                           input logic [15:0] nv, input logic [7:0] vc, input logic [1:0] st,
                                           input logic hi);
    read_byte = 8'h00;
    case (c)
      flash_lock_pkg::cmd_read_sector_lock:   read_byte = {6'h00, lk}; // [R23]
      flash_lock_pkg::cmd_read_flag_register: read_byte = fl;
      flash_lock_pkg::cmd_read_nv_config:     read_byte = hi ? nv[15:8] : nv[7:0];
      flash_lock_pkg::cmd_read_vol_config:    read_byte = vc;
      flash_lock_pkg::cmd_read_status:        read_byte = {6'h00, st};
      default:                                read_byte = 8'h00;
    endcase
  endfunction

  // byte is re-read for every bit, unregistered, so flag reads stay live and repeat
  assign out_byte = read_byte(cmd_ff, lock_sel, flags_ff, nv_store_ff, vol_config_ff,
                              {write_enable_latch_ff, write_in_progress_ff},
                              (obit_ff == 3'h0) ? obyte_ff[0] : ~obyte_ff[0]);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      serial_out_line <= 1'b0;
      serial_out_oe   <= 1'b0;
      obyte_ff        <= 8'h00;
      obit_ff         <= 3'h0;
    end else if (cs_n || phase_ff != st_dout) begin
      serial_out_oe <= 1'b0; // [R4]
      obit_ff       <= 3'h0;
      obyte_ff      <= 8'h00;
    end else if (fall) begin
      serial_out_oe   <= 1'b1;
      serial_out_line <= out_byte[3'd7 - obit_ff]; // [R3] [R14]
      if (obit_ff == 3'h0) begin
        obyte_ff <= {7'h00, ~obyte_ff[0]};
      end
      obit_ff <= obit_ff + 3'h1;
    end
  end

  // ****************************************
  // lock bits
  // ****************************************
  // reset stands in for power-up; lock-down only drops here
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < (1 << sec_bits); i++) begin
        lock_mem[i] <= flash_lock_pkg::lock_reset_val[1:0];
      end
    end else if (exec_lock_w && !lock_sel[flash_lock_pkg::lock_down_bit]) begin
      lock_mem[sector_of(addr_ff)] <= data_ff[1:0] & flash_lock_pkg::lock_keep_mask[1:0]; // [R7] [R11] [R23]
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      modify_blocked_ff <= 1'b0;
    end else begin
      modify_blocked_ff <= mod_sel[flash_lock_pkg::lock_write_bit]; // [R8]
    end
  end

  // ****************************************
  // write-enable latch and progress
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      write_enable_latch_ff <= 1'b0;
    end else if (exec_wen || write_enable_cmd_ext) begin
      write_enable_latch_ff <= 1'b1; // [R13]
    end else if (exec_lock_w || exec_vol_w || nv_done) begin
      write_enable_latch_ff <= 1'b0; // [R11] [R19] [R22]
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nv_start_ff          <= 1'b0;
      write_in_progress_ff <= 1'b0;
    end else begin
      nv_start_ff          <= exec_nv_w; // [R18]
      write_in_progress_ff <= exec_nv_w | nv_start_ff | (nv_busy & ~nv_done) | ext_busy; // [R19]
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vol_config_ff <= flash_lock_pkg::vcfg_reset_val;
    end else if (exec_vol_w) begin
      vol_config_ff <= data_ff[7:0]; // [R22]
    end
  end

  // stored copy changes; active copy only ever takes the fixed reset value, at power-on
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nv_store_ff <= flash_lock_pkg::nvcfg_reset_val;
    end else if (exec_nv_w) begin
      nv_store_ff <= {data_ff[7:0], data_ff[15:8]};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nv_active_ff <= flash_lock_pkg::nvcfg_reset_val; // [R20]
    end else begin
      nv_active_ff <= nv_active_ff;
    end
  end

  // ****************************************
  // flag status
  // ****************************************
  // a set arriving with the clear wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags_ff <= 8'h80;
    end else begin
      flags_ff <= ((exec_clr ? (flags_ff & ~flash_lock_pkg::flag_error_mask) : flags_ff) // [R15]
                  | {2'b00, err_erase_set, err_prog_set, err_vpp_set, 1'b0, err_prot_set, 1'b0});
      flags_ff[flash_lock_pkg::flag_ctrl_bit]  <= ~busy; // [R18]
      flags_ff[flash_lock_pkg::flag_addr4_bit] <= four_byte_mode;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_lock_down_hold: assert property (@(posedge mclk) disable iff (rst)
    exec_lock_w && lock_sel[1] |=> lock_mem[sector_of($past(addr_ff))] == $past(lock_sel)) // [R7]
    else $error("locked-down sector changed");
  a_latch_clear: assert property (@(posedge mclk) disable iff (rst)
    (exec_lock_w || exec_vol_w) && !write_enable_cmd_ext |=> !write_enable_latch_ff) // [R11]
    else $error("latch not cleared after register write");
  a_busy_reject: assert property (@(posedge mclk) disable iff (rst)
    busy |-> !exec_lock_w && !exec_vol_w && !exec_nv_w) // [R12]
    else $error("write accepted while busy");
  a_need_wel: assert property (@(posedge mclk) disable iff (rst)
    !write_enable_latch_ff |-> !exec_lock_w && !exec_nv_w && !exec_vol_w) // [R13]
    else $error("write without latch");
  a_clr_flags: assert property (@(posedge mclk) disable iff (rst)
    exec_clr && !err_erase_set && !err_prog_set |=> flags_ff[5:4] == 2'b00) // [R15]
    else $error("errors not cleared");
  a_nv_wip: assert property (@(posedge mclk) disable iff (rst)
    exec_nv_w |=> write_in_progress_ff ##1 write_in_progress_ff) // [R19]
    else $error("progress not shown");
  a_vol_apply: assert property (@(posedge mclk) disable iff (rst)
    exec_vol_w |=> vol_config_ff == $past(data_ff[7:0])) // [R22]
    else $error("volatile byte not applied");
  a_out_release: assert property (@(posedge mclk) disable iff (rst)
    cs_n |=> !serial_out_oe) // [R4]
    else $error("output driven while deselected");
endmodule

// ### spi_host_model.sv
// spi host model: selects, shifts bytes in and out, and releases the flash command block
`timescale 1ns/100ps
module spi_host_model (
  input  wire logic mclk,
  input  wire logic miso,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi
);
  // half of the 400 ns link clock; sclk stands still low outside frames
  localparam int half = 4;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic select();
    cs_n <= 1'b0;
    tick(half);
  endtask
  task automatic send_bit(input logic b);
    sclk <= 1'b0;
    mosi <= b;
    tick(half);
    sclk <= 1'b1;
    tick(half);
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      send_bit(b[i]);
    end
  endtask
  task automatic send_addr(input logic [31:0] a, input logic wide);
    if (wide) begin
      send_byte(a[31:24]);
    end
    for (int i = 2; i >= 0; i--) begin
      send_byte(a[i*8 +: 8]);
    end
  endtask
  task automatic recv_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sclk <= 1'b0;
      tick(half);
      sclk <= 1'b1;
      tick(half - 1);
      // sample late in the high phase, the device output lags its fall by a few mclk
      @(negedge mclk);
      b[i] = miso;
      @(posedge mclk);
    end
  endtask
  task automatic deselect();
    sclk <= 1'b0;
    tick(half);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    tick(2 * half);
  endtask
endmodule

// ### flash_lock_config_register_ops_test.sv
// self-checking bench for the lock, flag and configuration register instructions
`timescale 1ns/100ps
module flash_lock_config_register_ops_test;
  localparam int nv_sim = 20;
  logic        mclk, rst, sclk, cs_n, mosi, miso, oe, oe_seen;
  logic        ext_busy, four_byte_mode, wen_ext, e_erase, e_prog, e_vpp, e_prot;
  logic        blocked, latch, in_prog;
  logic [31:0] modify_addr;
  logic [7:0]  vcfg;
  logic [15:0] nv_act, q;
  int          bad_count, total_checks, n;
  flash_lock_config_register_ops #(.nv_cycles(nv_sim)) dut_u (
    .mclk(mclk), .rst(rst), .sclk_pin(sclk), .cs_n_pin(cs_n), .serial_in_line(mosi),
    .serial_out_line(miso), .serial_out_oe(oe), .ext_busy(ext_busy), .four_byte_mode(four_byte_mode),
    .write_enable_cmd_ext(wen_ext), .err_erase_set(e_erase), .err_prog_set(e_prog),
    .err_vpp_set(e_vpp), .err_prot_set(e_prot), .modify_addr(modify_addr),
    .modify_blocked_ff(blocked), .write_enable_latch_ff(latch), .write_in_progress_ff(in_prog),
    .vol_config_ff(vcfg), .nv_active_ff(nv_act)
  );
  spi_host_model host_u (.mclk(mclk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (oe === 1'b1) oe_seen = 1'b1;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic op(input logic [7:0] cmd);
    host_u.select();
    host_u.send_byte(cmd);
    host_u.deselect();
  endtask
  // data goes out msb first from d[15]; nbits short of a byte boundary must be dropped
  task automatic wr_frame(input logic [7:0] cmd, input logic use_a, input logic [31:0] a,
                          input logic [15:0] d, input int nbits);
    host_u.select();
    host_u.send_byte(cmd);
    if (use_a) host_u.send_addr(a, four_byte_mode);
    for (int i = 0; i < nbits; i++) begin
      host_u.send_bit(d[15-i]);
    end
    host_u.deselect();
  endtask
  task automatic rd_frame(input logic [7:0] cmd, input logic use_a, input logic [31:0] a);
    host_u.select();
    host_u.send_byte(cmd);
    if (use_a) host_u.send_addr(a, four_byte_mode);
    host_u.recv_byte(q[15:8]);
    host_u.recv_byte(q[7:0]);
    host_u.deselect();
    chk(16'(oe), 16'h0000);
  endtask
  task automatic lock_rd(input logic [31:0] a, input logic [7:0] exp);
    rd_frame(flash_lock_pkg::cmd_read_sector_lock, 1'b1, a);
    chk({8'h00, q[15:8]}, {8'h00, exp});
  endtask
  task automatic lock_wr(input logic [31:0] a, input logic [7:0] d, input int nbits);
    wr_frame(flash_lock_pkg::cmd_write_sector_lock, 1'b1, a, {d, 8'h00}, nbits);
  endtask
  task automatic test_done(input string name);
    $display("test %s finished, mismatches so far %0d", name, bad_count);
  endtask
  initial begin
    // the whole sequence needs roughly 9000 cycles
    repeat (40000) @(posedge mclk);
    bad_count++;
    end_of_test();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    {ext_busy, four_byte_mode, wen_ext, e_erase, e_prog, e_vpp, e_prot} = 7'h00;
    modify_addr = 32'h0000_0000;
    oe_seen = 1'b0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({latch, in_prog, 6'h00, vcfg}, 16'h00FB);
    chk(nv_act, 16'hFFFF);
    lock_rd(32'h0005_1234, 8'h00);
    rd_frame(flash_lock_pkg::cmd_read_flag_register, 1'b0, 32'h0000_0000);
    chk(q, 16'h8080);
    test_done("reset");
    lock_wr(32'h0005_1234, 8'hFD, 8);
    lock_rd(32'h0005_0000, 8'h00);
    op(flash_lock_pkg::cmd_write_enable);
    chk(16'(latch), 16'h0001);
    lock_wr(32'h0005_1234, 8'hFD, 7);
    chk(16'(latch), 16'h0001);
    lock_rd(32'h0005_0000, 8'h00);
    op(flash_lock_pkg::cmd_write_enable);
    lock_wr(32'h0005_1234, 8'hFD, 8);
    chk(16'(latch), 16'h0000);
    lock_rd(32'h0005_FFFF, 8'h01);
    modify_addr <= 32'h0005_8000;
    repeat (3) @(posedge mclk);
    chk(16'(blocked), 16'h0001);
    modify_addr <= 32'h0006_8000;
    repeat (3) @(posedge mclk);
    chk(16'(blocked), 16'h0000);
    op(flash_lock_pkg::cmd_write_enable);
    lock_wr(32'h0005_0000, 8'h03, 8);
    wen_ext <= 1'b1;
    @(posedge mclk);
    wen_ext <= 1'b0;
    lock_wr(32'h0005_0000, 8'h00, 8);
    lock_rd(32'h0005_0000, 8'h03);
    test_done("lock");
    four_byte_mode <= 1'b1;
    rd_frame(flash_lock_pkg::cmd_read_flag_register, 1'b0, 32'h0000_0000);
    chk(q, 16'h8181);
    op(flash_lock_pkg::cmd_write_enable);
    lock_wr(32'h0107_0000, 8'h01, 8);
    lock_rd(32'h0107_0000, 8'h01);
    four_byte_mode <= 1'b0;
    lock_rd(32'h0007_0000, 8'h00);
    test_done("four byte");
    ext_busy <= 1'b1;
    oe_seen = 1'b0;
    rd_frame(flash_lock_pkg::cmd_read_sector_lock, 1'b1, 32'h0005_0000);
    chk(16'(oe_seen), 16'h0000);
    // controller-ready bit reads 0 while a cycle runs elsewhere
    rd_frame(flash_lock_pkg::cmd_read_flag_register, 1'b0, 32'h0000_0000);
    chk(q, 16'h0000);
    op(flash_lock_pkg::cmd_write_enable);
    lock_wr(32'h0006_0000, 8'h01, 8);
    ext_busy <= 1'b0;
    lock_rd(32'h0006_0000, 8'h00);
    test_done("busy");
    {e_erase, e_prog, e_vpp, e_prot} <= 4'hF;
    @(posedge mclk);
    {e_erase, e_prog, e_vpp, e_prot} <= 4'h0;
    rd_frame(flash_lock_pkg::cmd_read_flag_register, 1'b0, 32'h0000_0000);
    chk(q, 16'hBABA);
    op(flash_lock_pkg::cmd_write_enable);
    op(flash_lock_pkg::cmd_clear_error_flags);
    chk(16'(latch), 16'h0001);
    rd_frame(flash_lock_pkg::cmd_read_flag_register, 1'b0, 32'h0000_0000);
    chk(q, 16'h8080);
    test_done("flags");
    wr_frame(flash_lock_pkg::cmd_write_vol_config, 1'b0, 32'h0000_0000, 16'h5A00, 7);
    chk({latch, 7'h00, vcfg}, 16'h80FB);
    // status byte holds latch in bit 1 and progress in bit 0
    rd_frame(flash_lock_pkg::cmd_read_status, 1'b0, 32'h0000_0000);
    chk(q, 16'h0202);
    wr_frame(flash_lock_pkg::cmd_write_vol_config, 1'b0, 32'h0000_0000, 16'h5A00, 8);
    chk({latch, 7'h00, vcfg}, 16'h005A);
    rd_frame(flash_lock_pkg::cmd_read_vol_config, 1'b0, 32'h0000_0000);
    chk(q, 16'h5A5A);
    test_done("volatile");
    op(flash_lock_pkg::cmd_write_enable);
    wr_frame(flash_lock_pkg::cmd_write_nv_config, 1'b0, 32'h0000_0000, 16'h3412, 15);
    chk(16'(in_prog), 16'h0000);
    wr_frame(flash_lock_pkg::cmd_write_nv_config, 1'b0, 32'h0000_0000, 16'h3412, 16);
    chk(16'(in_prog), 16'h0001);
    n = 0;
    // sampled on the falling clock, away from the edge that updates it
    while (in_prog === 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    // the deselect tail already spent part of the timed cycle
    chk(16'(n > nv_sim - 10 && n <= nv_sim), 16'h0001);
    chk({latch, in_prog, 14'h0000}, 16'h0000);
    chk(nv_act, 16'hFFFF);
    // first byte returned is the low byte, sent first
    rd_frame(flash_lock_pkg::cmd_read_nv_config, 1'b0, 32'h0000_0000);
    chk(q, 16'h3412);
    test_done("nonvolatile");
    end_of_test();
  end
endmodule
